// ---- design/alsp_packer.sv ----
/*
  Codec-side slot packer: decodes controller slots, keeps the 64-word codec
  register file, packs ready, tags, status echo and converter data.
  Assumes bit clock, frame marker and controller data come from outside
  the clk domain; converters sit on clk; APB master on clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "alsp_map.svh"
module alsp_packer
  import alsp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // serial link
  input  wire logic        bit_clock,
  input  wire logic        frame_marker,
  input  wire logic        serial_out_line,
  output var  logic        serial_in_line,
  // record side converters
  input  wire logic [19:0] rec_left,
  input  wire logic [19:0] rec_right,
  input  wire logic [19:0] modem_in,
  input  wire logic [19:0] mic_in,
  // playback side converters
  output var  logic [19:0] play_left,
  output var  logic [19:0] play_right,
  output var  logic [19:0] modem_out,
  output var  logic        play_strobe,
  output var  logic        modem_strobe
);

  // ==================================================
  // declarations
  logic        bclk_s1, bclk_s2, bclk_d;
  logic        mark_s1, mark_s2, mark_d;
  logic        sdo_s1, sdo_s2;
  logic        rise, fall, frame_start, slot_end;
  alsp_link_e  state;
  logic [3:0]  slot;
  logic [4:0]  bsl;
  logic [18:0] rx_sh;
  alsp_slot_t  rx_word;
  logic [15:0] tags;
  alsp_slot_t  cmd;
  logic [15:0] regs [0:63];
  logic [6:0]  ctrl;
  logic [5:0]  apb_idx;
  logic        resp_pending;
  logic [6:0]  resp_idx;
  logic [15:0] tx0;
  alsp_slot_t  tx1, tx2, tx3, tx4, tx5, tx6;
  logic [15:0] frame_cnt;
  logic        ready, cmd_ok, rd_cmd, wr_cmd;
  logic        apb_wr, apb_setup, mapped;
  logic [3:0]  en;
  logic [1:0]  res;

  // ==================================================
  // functions
  // keep the converter's real resolution, zero the trailing bits
  function automatic alsp_slot_t res_mask(input alsp_slot_t d, input logic [1:0] r);
    alsp_slot_t m;
    m = 20'hfffff;
    if (r == `ALSP_RES_16) begin
      m = 20'hffff0;
    end else if (r == `ALSP_RES_18) begin
      m = 20'hffffc;
    end
    return d & m;
  endfunction : res_mask

  // register read; index 0 answers with the resolution report
  function automatic logic [15:0] rd_reg(input logic [5:0] w, input logic [1:0] r);
    logic [15:0] v;
    v = regs[w];
    if (w == 6'h00) begin
      v = {14'h0000, r};
    end
    return v;
  endfunction : rd_reg

  // ==================================================
  // control fields
  assign ready = ctrl[`ALSP_CTRL_RDY];
  assign en    = ctrl[`ALSP_CTRL_EN_HI:`ALSP_CTRL_EN_LO];
  assign res   = ctrl[`ALSP_CTRL_RS_HI:`ALSP_CTRL_RS_LO];

  // ==================================================
  // link input synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_d  <= 1'b0;
      mark_s1 <= 1'b0;
      mark_s2 <= 1'b0;
      sdo_s1  <= 1'b0;
      sdo_s2  <= 1'b0;
    end else begin
      bclk_s1 <= bit_clock;
      bclk_s2 <= bclk_s1;
      bclk_d  <= bclk_s2;
      mark_s1 <= frame_marker;
      mark_s2 <= mark_s1;
      sdo_s1  <= serial_out_line;
      sdo_s2  <= sdo_s1;
    end
  end

  // bit clock edges and frame marker seen at a falling edge
  assign rise = bclk_s2 & ~bclk_d;
  assign fall = ~bclk_s2 & bclk_d;
  assign frame_start = fall & mark_s2 & ~mark_d;
  assign slot_end    = fall & (state == LNK_RUN) & (bsl == 5'h00);
  assign rx_word     = {rx_sh, sdo_s2};

  // marker level as sampled at the previous falling edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mark_d <= 1'b0;
    end else if (fall) begin
      mark_d <= mark_s2;
    end
  end

  // ==================================================
  // frame position: slot number and bit within slot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= LNK_IDLE;
      slot  <= 4'h0;
      bsl   <= 5'h00;
    end else if (frame_start) begin
      state <= LNK_RUN;
      slot  <= 4'h0;
      bsl   <= `ALSP_S0_TOP;
    end else if (fall) begin
      case (state)
        LNK_RUN: begin
          if (bsl == 5'h00) begin
            if (slot == `ALSP_LAST_SLOT) begin
              state <= LNK_IDLE;
            end
            slot <= slot + 4'h1;
            bsl  <= `ALSP_SL_TOP;
          end else begin
            bsl <= bsl - 5'h01;
          end
        end
        default: begin
          state <= LNK_IDLE;
        end
      endcase
    end
  end

  // controller bits shift in at falling edges, MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sh <= 19'h00000;
    end else if (fall && state == LNK_RUN) begin
      rx_sh <= rx_word[18:0];
    end
  end

  // ==================================================
  // outgoing slot decode: tags, command, playback data
  assign cmd_ok = slot_end & (slot == 4'h2) & tags[`ALSP_S0_VALID] & tags[14];
  // bit 19 selects read or write
  assign rd_cmd = cmd_ok & cmd[`ALSP_CMD_BIT];
  // write data needs tagged slot 2
  assign wr_cmd = cmd_ok & ~cmd[`ALSP_CMD_BIT] & tags[13];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tags         <= 16'h0000;
      cmd          <= 20'h00000;
      play_left    <= 20'h00000;
      play_right   <= 20'h00000;
      modem_out    <= 20'h00000;
      play_strobe  <= 1'b0;
      modem_strobe <= 1'b0;
    end else begin
      play_strobe  <= 1'b0;
      modem_strobe <= 1'b0;
      if (slot_end) begin
        case (slot)
          4'h0: tags <= rx_word[15:0];
          4'h1: cmd <= rx_word;
          4'h3: begin
            if (tags[`ALSP_S0_VALID] && tags[12]) begin
              play_left <= rx_word;
            end
          end
          4'h4: begin
            if (tags[`ALSP_S0_VALID] && tags[11]) begin
              play_right  <= rx_word;
              play_strobe <= 1'b1;
            end
          end
          4'h5: begin
            if (tags[`ALSP_S0_VALID] && tags[10]) begin
              modem_out    <= rx_word;
              modem_strobe <= 1'b1;
            end
          end
          default: begin
            tags <= tags;
          end
        endcase
      end
    end
  end

  // ==================================================
  // codec register file, written from link and apb
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 64; i++) begin
        regs[i] <= 16'h0000;
      end
    end else if (wr_cmd) begin
      // odd index folds to even word
      regs[cmd[`ALSP_IDX_HI:`ALSP_IDX_LO+1]] <= rx_word[`ALSP_DAT_HI:`ALSP_DAT_LO];
    end else if (apb_wr && paddr == `ALSP_OFF_DATA) begin
      regs[apb_idx] <= pwdata[15:0];
    end
  end

  // pending read answer; a new read wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_pending <= 1'b0;
      resp_idx     <= 7'h00;
    end else begin
      if (frame_start) begin
        resp_pending <= 1'b0;
      end
      if (rd_cmd) begin
        resp_pending <= 1'b1;
        resp_idx     <= cmd[`ALSP_IDX_HI:`ALSP_IDX_LO];
      end
    end
  end

  // ==================================================
  // incoming frame contents latched at frame start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx0 <= 16'h0000;
      tx1 <= 20'h00000;
      tx2 <= 20'h00000;
      tx3 <= 20'h00000;
      tx4 <= 20'h00000;
      tx5 <= 20'h00000;
      tx6 <= 20'h00000;
    end else if (frame_start) begin
      // ready flag first; tags only for valid slots
      tx0 <= {ready, {2{resp_pending}}, en & {4{ready}}, 9'h000};
      tx1 <= resp_pending ? {1'b0, resp_idx, 12'h000} : 20'h00000;
      tx2 <= resp_pending ? {rd_reg(resp_idx[6:1], res), 4'h0} : 20'h00000;
      tx3 <= (ready && en[3]) ? res_mask(rec_left, res) : 20'h00000;
      tx4 <= (ready && en[2]) ? res_mask(rec_right, res) : 20'h00000;
      tx5 <= (ready && en[1]) ? res_mask(modem_in, res) : 20'h00000;
      tx6 <= (ready && en[0]) ? res_mask(mic_in, res) : 20'h00000;
    end
  end

  // bits change on bit clock rise; MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_in_line <= 1'b0;
    end else if (rise) begin
      if (state == LNK_RUN) begin
        case (slot)
          4'h0: serial_in_line <= tx0[bsl[3:0]];
          4'h1: serial_in_line <= tx1[bsl];
          4'h2: serial_in_line <= tx2[bsl];
          4'h3: serial_in_line <= tx3[bsl];
          4'h4: serial_in_line <= tx4[bsl];
          4'h5: serial_in_line <= tx5[bsl];
          4'h6: serial_in_line <= tx6[bsl];
          default: serial_in_line <= 1'b0;
        endcase
      end else begin
        serial_in_line <= 1'b0;
      end
    end
  end

  // frames seen, for software status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_cnt <= 16'h0000;
    end else if (frame_start) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // ==================================================
  // apb slave, zero wait states
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign mapped    = (paddr == `ALSP_OFF_CTRL) || (paddr == `ALSP_OFF_STAT) ||
                     (paddr == `ALSP_OFF_IDX)  || (paddr == `ALSP_OFF_DATA);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  // control and index registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl    <= `ALSP_CTRL_RST;
      apb_idx <= 6'h00;
    end else if (apb_wr) begin
      if (paddr == `ALSP_OFF_CTRL) begin
        ctrl <= pwdata[6:0];
      end
      if (paddr == `ALSP_OFF_IDX) begin
        apb_idx <= pwdata[5:0];
      end
    end
  end

  // read data staged in the setup cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      case (paddr)
        `ALSP_OFF_CTRL: prdata <= {25'h0000000, ctrl};
        `ALSP_OFF_STAT: prdata <= {frame_cnt, 5'h00, resp_idx, 2'h0, resp_pending,
                                   state == LNK_RUN};
        `ALSP_OFF_IDX:  prdata <= {26'h0000000, apb_idx};
        `ALSP_OFF_DATA: prdata <= {16'h0000, rd_reg(apb_idx, res)};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : alsp_packer
`default_nettype wire

// ---- design/alsp_map.svh ----
/*
  Constants of the codec-side slot packer: register offsets, field positions,
  slot geometry and reset values.
  Assumes inclusion by bare name from the package and the packer module.
*/
`ifndef ALSP_MAP_SVH
`define ALSP_MAP_SVH
// ==================================================
// apb register offsets
`define ALSP_OFF_CTRL   8'h00
`define ALSP_OFF_STAT   8'h04
`define ALSP_OFF_IDX    8'h08
`define ALSP_OFF_DATA   8'h0c
`define ALSP_CTRL_RST   7'h00
// ==================================================
// control fields: ready, slot 3..6 enables, resolution code
`define ALSP_CTRL_RDY   0
`define ALSP_CTRL_EN_HI 4
`define ALSP_CTRL_EN_LO 1
`define ALSP_CTRL_RS_HI 6
`define ALSP_CTRL_RS_LO 5
`define ALSP_RES_16     2'h0
`define ALSP_RES_18     2'h1
// ==================================================
// slot layout
`define ALSP_CMD_BIT    19
`define ALSP_IDX_HI     18
`define ALSP_IDX_LO     12
`define ALSP_DAT_HI     19
`define ALSP_DAT_LO     4
`define ALSP_S0_TOP     5'h0f
`define ALSP_SL_TOP     5'h13
`define ALSP_LAST_SLOT  4'hc
`define ALSP_S0_VALID   15
`endif

// ---- design/alsp_pkg.sv ----
/*
  Types shared by the codec-side slot packer.
  Assumes the constant header is on the include path.
*/
`include "alsp_map.svh"
package alsp_pkg;
  // link frame tracking state
  typedef enum logic [0:0] {
    LNK_IDLE = 1'b0,
    LNK_RUN  = 1'b1
  } alsp_link_e;
  typedef logic [19:0] alsp_slot_t;
endpackage : alsp_pkg

// ---- sim/alsp_assertions.sv ----
/*
  Checker of the codec slot packer: apb answers, incoming line timing,
  playback strobes and a quiet line before setup.
  Assumes binding to the packer top with all ports named alike.
*/
`timescale 1ns/10ps
`default_nettype none
module alsp_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // link and converters
  input wire logic        bit_clock,
  input wire logic        serial_in_line,
  input wire logic [19:0] play_left,
  input wire logic [19:0] play_right,
  input wire logic [19:0] modem_out,
  input wire logic        play_strobe,
  input wire logic        modem_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic ctrl_seen;
  logic acc;
  logic mapped;
  // ==========
  // helper decode
  assign acc    = psel && penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
  // remembers the first control write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_seen <= 1'b0;
    end else if (acc && pwrite && paddr == 8'h00) begin
      ctrl_seen <= 1'b1;
    end
  end
  sequence s_no_play8;
    !play_strobe [*8];
  endsequence
  sequence s_no_modem8;
    !modem_strobe [*8];
  endsequence
  sequence s_low3;
    !bit_clock [*3];
  endsequence
  // ==========
  // properties
  AST_MAP_ERR: assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not follow the map");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("slave error outside access phase");
  AST_ERR_DATA: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read returns data");
  AST_IN_SETTLED: assert property (s_low3 |=> $stable(serial_in_line))
    else $error("incoming bit moves in clock low phase");
  AST_QUIET: assert property (!ctrl_seen |-> !serial_in_line)
    else $error("incoming line high before setup");
  AST_STROBE_PULSE: assert property (play_strobe |=> !play_strobe)
    else $error("play strobe longer than a cycle");
  AST_RIGHT_STROBE: assert property ($changed(play_right) |-> ##[0:1] play_strobe)
    else $error("right sample moved without strobe");
  AST_LEFT_FIRST: assert property ($changed(play_left) |-> s_no_play8)
    else $error("left sample not a slot ahead");
  AST_MODEM_STROBE: assert property ($changed(modem_out) |-> ##[0:1] modem_strobe)
    else $error("modem sample moved without strobe");
  AST_MODEM_AFTER: assert property (play_strobe |=> s_no_modem8)
    else $error("modem strobe too close to play strobe");
endmodule : alsp_assertions
`default_nettype wire

// ---- sim/alsp_ctrl_model.sv ----
/*
  Controller model of the serial link: frame marker, outgoing bits,
  capture of each incoming frame.
  Assumes a free running bit clock and tx frame changed between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module alsp_ctrl_model (
  // link
  input  wire logic         bit_clock,
  input  wire logic         serial_in_line,
  output var  logic         frame_marker,
  output var  logic         serial_out_line,
  // frame buffers
  input  wire logic [255:0] tx_frame,
  output var  logic [255:0] rx_frame,
  output var  int           frames
);
  logic [7:0]   cnt;
  logic [7:0]   pos;
  logic [255:0] acc;
  // start values
  initial begin
    cnt = 8'h00;
    pos = 8'hff;
    frame_marker = 1'b0;
    serial_out_line = 1'b0;
    frames = 0;
  end
  // ==========
  // outgoing bits on rising edges
  // marker and slot zero
  always @(posedge bit_clock) begin
    frame_marker <= (cnt < 8'h10);
    serial_out_line <= tx_frame[~(cnt - 8'h01)];
    pos <= cnt - 8'h01;
    cnt <= cnt + 8'h01;
  end
  // capture on falling edges
  always @(negedge bit_clock) begin
    acc[~pos] <= serial_in_line;
    if (pos == 8'hff) begin
      rx_frame <= {acc[255:1], serial_in_line};
      frames <= frames + 1;
    end
  end
endmodule : alsp_ctrl_model
`default_nettype wire

// ---- sim/audio_link_slot_packer_bench.sv ----
/*
  Bench of the codec slot packer: apb tasks, controller model, frame checks.
  Assumes checker and model compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module audio_link_slot_packer_bench;
  logic         clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic         bit_clock, frame_marker, serial_out_line, serial_in_line;
  logic         play_strobe, modem_strobe;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [19:0]  rec_left, rec_right, modem_in, mic_in, play_left, play_right, modem_out;
  logic [255:0] tx_frame, rx_frame;
  int           frames, err_count, checks;
  localparam logic [79:0] full = {20'h12345, 20'habcde, 20'h0f0f3, 20'h7777b};
  localparam logic [79:0] m16  = {20'h12340, 20'habcd0, 20'h0f0f0, 20'h77770};
  // ==========
  // clocks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    bit_clock = 1'b0;
    #9;
    forever #80 bit_clock = ~bit_clock;
  end
  alsp_packer u_alsp_packer (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bit_clock, .frame_marker, .serial_out_line,
    .serial_in_line, .rec_left, .rec_right, .modem_in, .mic_in, .play_left, .play_right,
    .modem_out, .play_strobe, .modem_strobe);
  alsp_ctrl_model u_alsp_ctrl_model (.bit_clock, .serial_in_line, .frame_marker,
    .serial_out_line, .tx_frame, .rx_frame, .frames);
  // ==========
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_frame(input logic [255:0] e);
    for (int k = 0; k < 8; k++) begin
      chk(rx_frame[k*32 +: 32], e[k*32 +: 32]);
    end
  endtask : chk_frame
  function automatic logic [255:0] fr(input logic [15:0] s0, input logic [39:0] c,
                                      input logic [79:0] d);
    return {s0, c, d, 120'h0};
  endfunction : fr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wait_frame();
    int i;
    int f;
    f = frames;
    i = 0;
    while (frames == f && i < 3000) begin
      @(posedge clk);
      i++;
    end
    if (frames == f) begin
      err_count++;
      stop_test();
    end
  endtask : wait_frame
  task automatic xfer(input logic [255:0] t);
    wait_frame();
    tx_frame <= t;
    wait_frame();
    // idle frame afterwards so a command is never repeated
    tx_frame <= 256'h0;
  endtask : xfer
  // ==========
  // main sequence
  initial begin
    {psel, penable, pwrite, reset_n} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_frame = 256'h0;
    {rec_left, rec_right, modem_in, mic_in} = full;
    err_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(256'h0);
    chk_frame(256'h0);
    $display("test reset done");
    apb(1'b1, 8'h00, 32'h5f);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h5f);
    xfer(fr(16'hfc00, {1'b0, 7'h02, 12'h000, 16'hbeef, 4'h0}, {20'habcd0, 20'h12340,
      20'h55550, 20'h0}));
    chk_frame(fr(16'h9e00, 40'h0, full));
    chk({12'h0, play_left}, 32'habcd0);
    chk({12'h0, play_right}, 32'h12340);
    chk({12'h0, modem_out}, 32'h55550);
    $display("test link write done");
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'hbeef);
    apb(1'b1, 8'h0c, 32'h1234);
    apb(1'b1, 8'h00, 32'h1f);
    $display("test apb data done");
    xfer(fr(16'he000, {1'b1, 7'h03, 32'h0}, 80'h0));
    chk_frame(fr(16'h9e00, 40'h0, m16));
    wait_frame();
    chk_frame(fr(16'hfe00, {1'b0, 7'h03, 12'h000, 16'h1234, 4'h0}, m16));
    wait_frame();
    chk_frame(fr(16'h9e00, 40'h0, m16));
    $display("test link read done");
    stop_test();
  end
endmodule : audio_link_slot_packer_bench
bind alsp_packer alsp_assertions u_alsp_assertions (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .bit_clock, .serial_in_line, .play_left, .play_right,
  .modem_out, .play_strobe, .modem_strobe);
`default_nettype wire
